// >>> src/dpc_consts.vh
// Constants for the discharge protection configuration block.
// Assumes a 250 MHz core clock and a 10 us protection time base.
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DPC_SETUP_ADDR        8'h05
`define DPC_SETUP_RESET       8'h00
`define DPC_ADDR_W            8
`define DPC_DATA_W            8

// ----------------------------------------------------------------
// Field positions of the setup register
// ----------------------------------------------------------------
`define DPC_OC_INHIBIT_BIT    7
`define DPC_OC_LEVEL_HI_BIT   6
`define DPC_OC_LEVEL_LO_BIT   5
`define DPC_SC_INHIBIT_BIT    4
`define DPC_SC_LEVEL_HI_BIT   3
`define DPC_SC_LEVEL_LO_BIT   2
`define DPC_OC_DELAY_HI_BIT   1
`define DPC_OC_DELAY_LO_BIT   0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DPC_CLK_PERIOD_PS     4000
`define DPC_TICK_PS           10000000
// 10 us of 4 ns cycles, sized for the tick counter
`define DPC_TICK_CYCLES       12'h9C4
`define DPC_TICK_CNT_W        12
`define DPC_TIME_W            18
// Qualifying times in microseconds, as specified
`define DPC_OC_T0_US          160000
`define DPC_OC_T1_US          320000
`define DPC_OC_T2_US          640000
`define DPC_OC_T3_US          1280000
`define DPC_OC_F0_US          2500
`define DPC_OC_F1_US          5000
`define DPC_OC_F2_US          8000
`define DPC_OC_F3_US          16000
`define DPC_SC_SHORT_US       100
`define DPC_SC_LONG_US        10000
`define DPC_TICK_US           10

`endif

// >>> src/dpc_qualify.v
// Qualifying timer for one fault comparator.
// Assumes the comparator input is asynchronous and i_tick is a
// one-cycle pulse every time-base period.
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_qualify (
    input  wire                   i_clk,
    input  wire                   i_rst_n,
    input  wire                   i_tick,
    input  wire                   i_cmp,
    input  wire [`DPC_TIME_W-1:0] i_limit,
    output reg                    o_fire
);

    reg  [2:0]             sync;
    reg                    cond;
    reg  [`DPC_TIME_W-1:0] count;
    reg                    done;

    // ------------------------------------------------------------
    // Three-stage synchroniser; level accepted when the last two stages agree
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync <= 3'h0;
            cond <= 1'b0;
        end else begin
            sync <= {sync[1:0], i_cmp};
            if (sync[1] == sync[2]) begin
                cond <= sync[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Persistence counter
    // ------------------------------------------------------------
    // One extra tick is counted because the first tick can land
    // at any phase; this keeps the delay a least time.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count  <= {`DPC_TIME_W{1'b0}};
            done   <= 1'b0;
            o_fire <= 1'b0;
        end else begin
            o_fire <= 1'b0;
            if (!cond) begin
                count <= {`DPC_TIME_W{1'b0}};
                done  <= 1'b0;
            end else if (i_tick && !done) begin
                if (count >= i_limit) begin
                    o_fire <= 1'b1;
                    done   <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule

// >>> src/dpc_top.v
// Discharge protection setup register and fault response logic.
// Assumes the serial port logic presents decoded register accesses,
// and analog comparators take the threshold selects as trip levels.
// Flag clears and switch writes arrive from registers kept elsewhere.
// What this block does
// - OC inhibit bit 0 lets discharge overcurrent turn off FETs.
// - OC inhibit bit 1 leaves FETs alone on overcurrent.
// - Overcurrent always sets its flag; flag powers thermistor supply.
// - Bits 6:5 select overcurrent trip 0.10/0.12/0.14/0.16 V.
// - Short inhibit bit 4 at 0 lets short circuit turn off FETs.
// - Short inhibit bit at 1 keeps FETs on for short circuit.
// - Short circuit always sets its flag; flag powers thermistor.
// - Bits 3:2 select short trip 0.20/0.35/0.65/1.20 V.
// - Bits 1:0 select overcurrent delay 160/320/640/1280 ms.
// - With fast scale set, delays are 2.5/5/8/16 ms.
// - Fast scale bit shortens overcurrent delay 64 times (codes 0-1) or 80 times (codes 2-3).
// - Short long-delay select: 100 us when 0, 10 ms when 1.
// - Automatic shutdown clears discharge switch bit unless inhibited.
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_top #(
    parameter [`DPC_TICK_CNT_W-1:0] TICK_CYCLES = `DPC_TICK_CYCLES
) (
    input  wire                  i_clk,
    input  wire                  i_rst_n,
    input  wire                  i_reg_wr,
    input  wire                  i_reg_rd,
    input  wire [`DPC_ADDR_W-1:0] i_reg_addr,
    input  wire [`DPC_DATA_W-1:0] i_reg_wdata,
    output reg  [`DPC_DATA_W-1:0] o_reg_rdata,
    input  wire                  i_disch_delay_fast_scale,
    input  wire                  i_short_long_delay_sel,
    input  wire                  i_switch_wr,
    input  wire                  i_switch_wdata,
    input  wire                  i_disch_oc_flag_clr,
    input  wire                  i_short_flag_clr,
    input  wire                  i_disch_oc_cmp,
    input  wire                  i_short_cmp,
    output wire [1:0]            o_disch_oc_trip_voltage,
    output wire [1:0]            o_short_trip_voltage,
    output reg                   o_disch_oc_flag,
    output reg                   o_short_flag,
    output reg                   o_thermistor_supply_out,
    output reg                   o_discharge_switch_ctrl
);

    reg  [`DPC_DATA_W-1:0]      setup;
    reg  [`DPC_TICK_CNT_W-1:0]  tick_cnt;
    reg                         tick;
    wire                        oc_fire;
    wire                        sc_fire;
    wire [`DPC_TIME_W-1:0]      oc_limit;
    wire [`DPC_TIME_W-1:0]      sc_limit;
    wire                        disch_oc_autooff_inhibit;
    wire                        short_autooff_inhibit;
    wire [1:0]                  disch_oc_delay;
    wire [1:0]                  chan_cmp;
    wire [2*`DPC_TIME_W-1:0]    chan_limit;
    wire [1:0]                  chan_fire;

    // Microseconds to time-base ticks
    function [`DPC_TIME_W-1:0] us_to_ticks;
        input [31:0] us;
        reg   [31:0] t;
        begin
            t = us / `DPC_TICK_US;
            us_to_ticks = t[`DPC_TIME_W-1:0];
        end
    endfunction

    function [`DPC_TIME_W-1:0] oc_delay_ticks;
        input [1:0] code;
        input       fast;
        begin
            case ({fast, code})
                3'h0:    oc_delay_ticks = us_to_ticks(`DPC_OC_T0_US);
                3'h1:    oc_delay_ticks = us_to_ticks(`DPC_OC_T1_US);
                3'h2:    oc_delay_ticks = us_to_ticks(`DPC_OC_T2_US);
                3'h3:    oc_delay_ticks = us_to_ticks(`DPC_OC_T3_US);
                3'h4:    oc_delay_ticks = us_to_ticks(`DPC_OC_F0_US);
                3'h5:    oc_delay_ticks = us_to_ticks(`DPC_OC_F1_US);
                3'h6:    oc_delay_ticks = us_to_ticks(`DPC_OC_F2_US);
                default: oc_delay_ticks = us_to_ticks(`DPC_OC_F3_US);
            endcase
        end
    endfunction

    function reg_hit;
        input [`DPC_ADDR_W-1:0] addr;
        begin
            reg_hit = (addr == `DPC_SETUP_ADDR);
        end
    endfunction

    // Turn-off request of one fault channel
    function auto_off;
        input fire;
        input inhibit;
        begin
            auto_off = fire && !inhibit;
        end
    endfunction

    // ------------------------------------------------------------
    // Setup register
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            setup <= `DPC_SETUP_RESET;
        end else if (i_reg_wr && reg_hit(i_reg_addr)) begin
            setup <= i_reg_wdata;
        end
    end

    // Read data stands one cycle, zero otherwise
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd && reg_hit(i_reg_addr)) begin
            o_reg_rdata <= setup;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    assign disch_oc_autooff_inhibit = setup[`DPC_OC_INHIBIT_BIT];
    assign short_autooff_inhibit    = setup[`DPC_SC_INHIBIT_BIT];
    assign disch_oc_delay = setup[`DPC_OC_DELAY_HI_BIT:`DPC_OC_DELAY_LO_BIT];
    // Codes drive the analog comparator reference selects
    assign o_disch_oc_trip_voltage =
        setup[`DPC_OC_LEVEL_HI_BIT:`DPC_OC_LEVEL_LO_BIT];
    assign o_short_trip_voltage =
        setup[`DPC_SC_LEVEL_HI_BIT:`DPC_SC_LEVEL_LO_BIT];

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // One enable pulse per period paces both fault channels
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= {`DPC_TICK_CNT_W{1'b0}};
            tick     <= 1'b0;
        end else if (tick_cnt >= TICK_CYCLES - 1'b1) begin
            tick_cnt <= {`DPC_TICK_CNT_W{1'b0}};
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Fault qualification
    // ------------------------------------------------------------
    // Limits are live, so a new setting governs a detection already in progress.
    assign oc_limit = oc_delay_ticks(disch_oc_delay,
                                     i_disch_delay_fast_scale);
    assign sc_limit = i_short_long_delay_sel ?
                      us_to_ticks(`DPC_SC_LONG_US) :
                      us_to_ticks(`DPC_SC_SHORT_US);
    assign chan_cmp   = {i_short_cmp, i_disch_oc_cmp};
    assign chan_limit = {sc_limit, oc_limit};
    assign oc_fire    = chan_fire[0];
    assign sc_fire    = chan_fire[1];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_qual
            dpc_qualify u_qual (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_tick  (tick),
                .i_cmp   (chan_cmp[g]),
                .i_limit (chan_limit[g*`DPC_TIME_W +: `DPC_TIME_W]),
                .o_fire  (chan_fire[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Flags, thermistor supply and discharge switch
    // ------------------------------------------------------------
    // A fault in the clear cycle wins over the clear.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_disch_oc_flag <= 1'b0;
        end else if (oc_fire) begin
            o_disch_oc_flag <= 1'b1;
        end else if (i_disch_oc_flag_clr) begin
            o_disch_oc_flag <= 1'b0;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_short_flag <= 1'b0;
        end else if (sc_fire) begin
            o_short_flag <= 1'b1;
        end else if (i_short_flag_clr) begin
            o_short_flag <= 1'b0;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_thermistor_supply_out <= 1'b0;
        end else begin
            o_thermistor_supply_out <= o_disch_oc_flag |
                                       o_short_flag;
        end
    end

    // Automatic turn-off beats a software write in the same cycle
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_discharge_switch_ctrl <= 1'b0;
        end else if (auto_off(oc_fire, disch_oc_autooff_inhibit) ||
                     auto_off(sc_fire, short_autooff_inhibit)) begin
            o_discharge_switch_ctrl <= 1'b0;
        end else if (i_switch_wr) begin
            o_discharge_switch_ctrl <= i_switch_wdata;
        end
    end

endmodule

// >>> dv/dpc_props.sv
// Port checker for the discharge protection setup block.
// Assumes one clock domain; bound to dpc_top from the testbench top.
`timescale 1ns/1ps
module dpc_props (
    input logic       i_clk,
    input logic       i_rst_n,
    input logic       i_reg_wr,
    input logic       i_reg_rd,
    input logic [7:0] i_reg_addr,
    input logic [7:0] i_reg_wdata,
    input logic [7:0] o_reg_rdata,
    input logic       i_switch_wr,
    input logic       i_short_cmp,
    input logic [1:0] o_disch_oc_trip_voltage,
    input logic [1:0] o_short_trip_voltage,
    input logic       o_disch_oc_flag,
    input logic       o_short_flag,
    input logic       o_thermistor_supply_out,
    input logic       o_discharge_switch_ctrl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_oc_lvl_follow: assert property (i_reg_wr && i_reg_addr == 8'h05
        |=> o_disch_oc_trip_voltage == $past(i_reg_wdata[6:5]))
        else $error("oc trip select not updated");
    a_sc_lvl_follow: assert property (i_reg_wr && i_reg_addr == 8'h05
        |=> o_short_trip_voltage == $past(i_reg_wdata[3:2]))
        else $error("short trip select not updated");
    a_read_hit: assert property (i_reg_rd && !i_reg_wr
        && i_reg_addr == 8'h05
        |=> o_reg_rdata[3:2] == $past(o_short_trip_voltage)
        && o_reg_rdata[6:5] == $past(o_disch_oc_trip_voltage))
        else $error("read data differs from setup");
    a_read_miss: assert property (i_reg_rd && i_reg_addr != 8'h05
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_therm_oc: assert property ($rose(o_disch_oc_flag)
        |=> o_thermistor_supply_out)
        else $error("supply off after oc flag");
    a_therm_sc: assert property ($rose(o_short_flag)
        |=> o_thermistor_supply_out)
        else $error("supply off after short flag");
    a_switch_off_cause: assert property (
        $fell(o_discharge_switch_ctrl) && !$past(i_switch_wr)
        |-> $rose(o_disch_oc_flag) || $rose(o_short_flag))
        else $error("switch cleared without a fault");
    a_sc_needs_cmp: assert property ($rose(o_short_flag)
        |-> $past(i_short_cmp, 8))
        else $error("short flag without lasting fault");

    c_oc_fire: cover property ($rose(o_disch_oc_flag));
    c_sc_fire: cover property ($rose(o_short_flag));
    c_auto_off: cover property ($fell(o_discharge_switch_ctrl)
        && !$past(i_switch_wr));
endmodule

// >>> dv/dpc_mcu.sv
// Microcontroller model: register writes and reads on the strobe port.
// Assumes its tasks are called from the testbench top.
`timescale 1ns/1ps
module dpc_mcu (
    input  logic       i_clk,
    input  logic [7:0] i_reg_rdata,
    output logic       o_reg_wr = 0,
    output logic       o_reg_rd = 0,
    output logic [7:0] o_reg_addr = 8'h00,
    output logic [7:0] o_reg_wdata = 8'h00
);
    // Released lines show inverted values so stale data is never reused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_reg_wr = 1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(negedge i_clk);
        o_reg_wr = 0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_reg_rd = 1;
        o_reg_addr = a;
        @(negedge i_clk);
        o_reg_rd = 0;
        o_reg_addr = ~a;
        d = i_reg_rdata;
    endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench for the discharge protection setup block.
// Assumes a tick of 4 cycles so every fault delay stays short.
`timescale 1ns/1ps
module tb;
    logic       i_clk = 0;
    logic       i_rst_n = 0;
    logic       fast = 0, lsel = 0, sw_wr = 0, sw_d = 0;
    logic       oc_clr = 0, sc_clr = 0, oc_cmp = 0, sc_cmp = 0;
    logic       wr, rd, oc_f, sc_f, therm, sw;
    logic [7:0] addr, wdata, rdata, v;
    logic [1:0] oc_lv, sc_lv;
    int         failures = 0;
    int         checks = 0;
    int         n;

    dpc_top #(.TICK_CYCLES(12'h004)) uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_disch_delay_fast_scale(fast), .i_short_long_delay_sel(lsel),
        .i_switch_wr(sw_wr), .i_switch_wdata(sw_d),
        .i_disch_oc_flag_clr(oc_clr), .i_short_flag_clr(sc_clr),
        .i_disch_oc_cmp(oc_cmp), .i_short_cmp(sc_cmp),
        .o_disch_oc_trip_voltage(oc_lv), .o_short_trip_voltage(sc_lv),
        .o_disch_oc_flag(oc_f), .o_short_flag(sc_f),
        .o_thermistor_supply_out(therm), .o_discharge_switch_ctrl(sw));
    dpc_mcu mcu (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));

    initial forever #2 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Arms the switch, clears flags, holds one comparator until its flag
    task automatic fire(input logic oc, input logic [7:0] setup);
        @(negedge i_clk);
        {oc_clr, sc_clr, sw_wr, sw_d} = 4'hF;
        @(negedge i_clk);
        {oc_clr, sc_clr, sw_wr} = 3'h0;
        mcu.wr(8'h05, setup);
        {oc_cmp, sc_cmp} = {oc, !oc};
        n = 0;
        while ((oc ? oc_f : sc_f) !== 1'b1 && n < 8000) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 8000) begin
            failures++;
            $display("ERROR %0t flag never set", $time);
            end_sim();
        end
        repeat (2) @(negedge i_clk);
        {oc_cmp, sc_cmp} = 2'h0;
    endtask

    task automatic t_regs;
        mcu.rd(8'h05, v);
        chk(v, 8'h00, "reset value");
        mcu.wr(8'h05, 8'hA6);
        mcu.wr(8'h06, 8'h5A);
        mcu.rd(8'h06, v);
        chk(v, 8'h00, "unmapped read");
        mcu.rd(8'h05, v);
        chk(v, 8'hA6, "read back");
        $display("test regs done");
    endtask

    task automatic t_levels;
        for (int c = 0; c < 4; c++) begin
            mcu.wr(8'h05, {1'b0, c[1:0], 1'b0, c[1:0], 2'h0});
            chk(oc_lv, c, "oc level");
            chk(sc_lv, c, "short level");
        end
        $display("test levels done");
    endtask

    task automatic t_oc;
        int lim [4] = '{250, 500, 800, 1600};
        fast = 1;
        for (int c = 0; c < 4; c++) begin
            fire(1, {c[0], 2'h3, 1'b0, 2'h0, c[1:0]});
            chk(n >= lim[c] * 4 && n <= lim[c] * 4 + 16, 1,
                "oc delay");
            chk(sw, c[0], "oc switch");
            chk(therm, 1, "oc supply");
        end
        // Slow scale must still be quiet just past the longest fast delay
        fast = 0;
        mcu.wr(8'h05, 8'h00);
        oc_clr = 1;
        @(negedge i_clk);
        oc_clr = 0;
        oc_cmp = 1;
        repeat (6800) @(negedge i_clk);
        chk(oc_f, 0, "oc slow scale");
        oc_cmp = 0;
        $display("test oc done");
    endtask

    task automatic t_short;
        for (int c = 0; c < 4; c++) begin
            lsel = c[1];
            fire(0, {3'h0, c[0], 2'h3, 2'h0});
            chk(n >= (c[1] ? 4000 : 40) && n <= (c[1] ? 4016 : 56), 1,
                "short delay");
            chk(sw, c[0], "short switch");
            chk(sc_f & therm, 1, "short supply");
        end
        $display("test short done");
    endtask

    initial begin
        repeat (12) @(negedge i_clk);
        i_rst_n = 1;
        t_regs();
        t_levels();
        t_oc();
        t_short();
        end_sim();
    end
endmodule

bind dpc_top dpc_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_switch_wr(i_switch_wr), .i_short_cmp(i_short_cmp),
    .o_disch_oc_trip_voltage(o_disch_oc_trip_voltage),
    .o_short_trip_voltage(o_short_trip_voltage),
    .o_disch_oc_flag(o_disch_oc_flag), .o_short_flag(o_short_flag),
    .o_thermistor_supply_out(o_thermistor_supply_out),
    .o_discharge_switch_ctrl(o_discharge_switch_ctrl));
